// *** homing_pkg.sv ***
/*
  homing_pkg: constants shared by the return-to-home sequencer and its helpers.
  Assumes a 100 MHz system clock; speed values are Hz counts, position values step counts.
*/
package homing_pkg;

  // -----------------------------------------------------------------
  // modes and defaults
  // -----------------------------------------------------------------
  localparam logic [1:0] MODE_TWO_SENSOR = 2'h0;
  localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;
  localparam logic [1:0] MODE_DEFAULT = 2'h1;
  localparam logic [1:0] MODE_LAST = 2'h2;

  localparam int POS_WIDTH = 32;
  localparam int OFFSET_WIDTH = 24;
  localparam int SPEED_WIDTH = 20;
  localparam int ACCEL_WIDTH = 20;
  localparam int CURRENT_WIDTH = 10;

  localparam logic [SPEED_WIDTH-1:0] RUN_SPEED_DEFAULT = 20'h003e8;
  localparam logic [SPEED_WIDTH-1:0] START_SPEED_DEFAULT = 20'h001f4;
  localparam logic [SPEED_WIDTH-1:0] SPEED_MIN = 20'h00001;
  localparam logic [SPEED_WIDTH-1:0] SPEED_MAX = 20'hf4240;
  localparam logic [SPEED_WIDTH-1:0] FINAL_SPEED_CAP = 20'h001f4;
  localparam logic [ACCEL_WIDTH-1:0] ACCEL_DEFAULT = 20'h003e8;
  localparam logic [ACCEL_WIDTH-1:0] ACCEL_MAX = 20'hf4240;
  localparam logic [CURRENT_WIDTH-1:0] PUSH_CURRENT_DEFAULT = 10'h3e8;
  localparam logic [CURRENT_WIDTH-1:0] PUSH_CURRENT_MAX = 10'h3e8;
  localparam logic [OFFSET_WIDTH-1:0] OFFSET_DEFAULT = 24'h000000;
  localparam logic DIR_DEFAULT = 1'b1;
  localparam logic SLOT_EN_DEFAULT = 1'b0;
  localparam logic MARKER_EN_DEFAULT = 1'b0;

  // -----------------------------------------------------------------
  // motion constants
  // -----------------------------------------------------------------
  localparam logic [POS_WIDTH-1:0] ESCAPE_STEPS = 32'h000000c8;
  localparam logic [POS_WIDTH-1:0] HOME_POSITION = 32'h00000000;

endpackage : homing_pkg

// *** edge_sync.sv ***
/*
  edge_sync: two-flop synchroniser with a rising-edge detector on the
  synchronised level. Input may be asynchronous; reset is async, active high.
*/
`timescale 1ns/10ps
module edge_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // raw level in
  input wire logic raw_in,
  // synchronised level and its rising edge
  output logic level_out,
  output logic rise_out
);

  logic meta_r;
  logic level_r;
  logic prev_r;
  logic [2:0] arm_r;

  // first flop feeds only the second flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= 1'b0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
      arm_r <= 3'h0;
    end
    else
    begin
      meta_r <= raw_in;
      level_r <= meta_r;
      prev_r <= level_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // edges are held off until prev_r holds a real sample, so a pin that is high
  // through reset gives no false edge; a true edge inside that window is lost
  assign level_out = level_r;
  assign rise_out = level_r & ~prev_r & arm_r[2];

endmodule : edge_sync

// *** step_counter.sv ***
/*
  step_counter: counts step pulses of a positioning move down to zero.
  Assumes step_pulse is a one-cycle strobe from the pulse generator.
*/
`timescale 1ns/10ps
module step_counter
#(
  parameter int WIDTH = 32
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // load and step
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic step_pulse,
  // state
  output logic done
);

  logic [WIDTH-1:0] count_r;

  // the escape and offset counts need at least a byte
  if (WIDTH < 8)
  begin : g_bad_width
    $error("step_counter width too small");
  end

  // load wins over a step arriving the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      count_r <= '0;
    else if (load)
      count_r <= load_value;
    else if (step_pulse && count_r != '0)
      count_r <= count_r - WIDTH'(1);
  end

  assign done = (count_r == '0);

endmodule : step_counter

// *** return_to_home_sequencer.sv ***
/*
  return_to_home_sequencer: finds mechanical home in 2-sensor, 3-sensor or
  push mode, or loads a preset position; optional offset move and final
  edge from the slot sensor or the phase marker in 2-sensor and 3-sensor modes.
  Assumes an external pulse engine turns the speed/direction/run outputs
  into steps and returns one step_pulse per step; sensor and request inputs may be asynchronous.
*/
`timescale 1ns/10ps
module return_to_home_sequencer
  import homing_pkg::*;
#(
  parameter logic [1:0] HOME_MODE = MODE_DEFAULT,
  parameter logic [SPEED_WIDTH-1:0] RUN_SPEED = RUN_SPEED_DEFAULT,
  parameter logic [SPEED_WIDTH-1:0] START_SPEED = START_SPEED_DEFAULT,
  parameter logic [ACCEL_WIDTH-1:0] ACCEL_RATE = ACCEL_DEFAULT,
  parameter logic [CURRENT_WIDTH-1:0] PUSH_CURRENT = PUSH_CURRENT_DEFAULT
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host handshake
  input wire logic home_request,
  input wire logic preset_request,
  output logic ready,
  output logic home_complete,
  // configuration
  input wire logic start_positive,
  input wire logic slot_detect_en,
  input wire logic marker_detect_en,
  input wire logic signed [OFFSET_WIDTH-1:0] home_offset,
  input wire logic [POS_WIDTH-1:0] preset_position,
  // machine-side sensors
  input wire logic origin_sensor,
  input wire logic travel_limit_pos,
  input wire logic travel_limit_neg,
  input wire logic stall_detect,
  input wire logic slot_sensor_input,
  input wire logic phase_marker_signal,
  // pulse engine
  input wire logic step_pulse,
  output logic motor_run,
  output logic motor_dir_pos,
  output logic [SPEED_WIDTH-1:0] motor_speed,
  output logic [ACCEL_WIDTH-1:0] motor_accel,
  output logic [CURRENT_WIDTH-1:0] motor_current,
  output logic push_current_on,
  output logic [POS_WIDTH-1:0] command_position
);

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  if (HOME_MODE > MODE_LAST ||
      RUN_SPEED < SPEED_MIN || RUN_SPEED > SPEED_MAX ||
      START_SPEED < SPEED_MIN || START_SPEED > SPEED_MAX ||
      ACCEL_RATE == '0 || ACCEL_RATE > ACCEL_MAX ||
      PUSH_CURRENT > PUSH_CURRENT_MAX)
  begin : g_bad_config
    $error("homing parameter out of range");
  end

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] lvl;
  logic [NSYNC-1:0] rise;

  assign raw_in = {preset_request, home_request, stall_detect, phase_marker_signal,
                   slot_sensor_input, travel_limit_neg, travel_limit_pos, origin_sensor};

  // every rising edge of a sensor or request seen once, after two flops; none in the first three cycles out of reset
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      edge_sync u_sync
      (
        .clk(clk),
        .reset(reset),
        .raw_in(raw_in[gi]),
        .level_out(lvl[gi]),
        .rise_out(rise[gi])
      );
    end
  endgenerate

  logic origin_lvl;
  logic origin_rise;
  logic limit_pos_lvl;
  logic limit_neg_lvl;
  logic limit_rise;
  logic stall_rise;
  logic extra_rise;
  logic home_req_rise;
  logic preset_rise;
  logic extra_en;

  assign origin_lvl = lvl[0];
  assign origin_rise = rise[0];
  assign limit_pos_lvl = lvl[1];
  assign limit_neg_lvl = lvl[2];
  assign limit_rise = rise[1] | rise[2];
  assign stall_rise = rise[5];
  assign home_req_rise = rise[6];
  assign preset_rise = rise[7];
  // extra final-edge condition from slot sensor and/or phase marker
  assign extra_en = slot_detect_en | marker_detect_en;
  assign extra_rise = (slot_detect_en & rise[3]) | (marker_detect_en & rise[4]);

  // -----------------------------------------------------------------
  // speed selection
  // -----------------------------------------------------------------
  logic [SPEED_WIDTH-1:0] final_speed;
  // final approach never above the cap
  assign final_speed = (START_SPEED < FINAL_SPEED_CAP) ? START_SPEED : FINAL_SPEED_CAP;

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK,
    ST_ESCAPE,
    ST_TRAVEL,
    ST_EXTRA,
    ST_OFFSET
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic dir_r;
  logic dir_nxt;
  logic ready_r;
  logic ready_nxt;
  logic complete_r;
  logic complete_nxt;
  logic run_r;
  logic run_nxt;
  logic [SPEED_WIDTH-1:0] speed_r;
  logic [SPEED_WIDTH-1:0] speed_nxt;
  logic push_on_r;
  logic push_on_nxt;
  logic [POS_WIDTH-1:0] cmd_pos_r;
  logic [POS_WIDTH-1:0] cmd_pos_nxt;
  logic [ACCEL_WIDTH-1:0] accel_r;
  logic [CURRENT_WIDTH-1:0] current_r;
  logic cnt_load;
  logic [POS_WIDTH-1:0] cnt_value;
  logic cnt_done;
  logic [POS_WIDTH-1:0] offset_ext;
  logic [POS_WIDTH-1:0] offset_mag;
  logic dir_limit_lvl;

  // sign-extend offset; magnitude counts steps of the offset move
  assign offset_ext = {{(POS_WIDTH-OFFSET_WIDTH){home_offset[OFFSET_WIDTH-1]}}, home_offset};
  assign offset_mag = home_offset[OFFSET_WIDTH-1] ? (~offset_ext + 32'h00000001) : offset_ext;
  assign dir_limit_lvl = dir_r ? limit_pos_lvl : limit_neg_lvl;

  step_counter #(.WIDTH(POS_WIDTH)) u_count
  (
    .clk(clk),
    .reset(reset),
    .load(cnt_load),
    .load_value(cnt_value),
    .step_pulse(step_pulse),
    .done(cnt_done)
  );

  // next-state logic; host must hold request until ready drops, so a
  // rising edge is the start trigger
  always_comb
  begin
    state_nxt = state_r;
    dir_nxt = dir_r;
    ready_nxt = ready_r;
    complete_nxt = complete_r;
    run_nxt = run_r;
    speed_nxt = speed_r;
    push_on_nxt = push_on_r;
    cmd_pos_nxt = cmd_pos_r;
    cnt_load = 1'b0;
    cnt_value = ESCAPE_STEPS;
    // command position tracks steps while moving
    if (run_r && step_pulse)
      cmd_pos_nxt = dir_r ? cmd_pos_r + 32'h00000001 : cmd_pos_r - 32'h00000001;
    case (state_r)
      ST_IDLE:
      begin
        if (ready_r && home_req_rise)
        begin
          ready_nxt = 1'b0;
          complete_nxt = 1'b0;
          dir_nxt = start_positive;
          run_nxt = 1'b1;
          state_nxt = ST_SEEK;
          // three-sensor runs fast, the others creep at start speed
          speed_nxt = (HOME_MODE == MODE_THREE_SENSOR) ? RUN_SPEED : START_SPEED;
          push_on_nxt = (HOME_MODE == MODE_PUSH);
        end
        else if (ready_r && preset_rise && !run_r)
          cmd_pos_nxt = preset_position;
      end
      ST_SEEK:
      begin
        if (HOME_MODE == MODE_THREE_SENSOR)
        begin
          // limit in travel direction reverses; absent limits simply never fire
          if (origin_rise || (origin_lvl && !extra_en))
          begin
            if (extra_en)
            begin
              speed_nxt = final_speed;
              state_nxt = ST_EXTRA;
            end
            else
            begin
              run_nxt = 1'b0;
              cmd_pos_nxt = HOME_POSITION;
              state_nxt = ST_OFFSET;
            end
          end
          else if (limit_rise && dir_limit_lvl)
            dir_nxt = ~dir_r;
        end
        else if ((HOME_MODE == MODE_TWO_SENSOR && limit_rise) ||
                 (HOME_MODE == MODE_PUSH && stall_rise))
        begin
          dir_nxt = ~dir_r;
          push_on_nxt = 1'b0;
          state_nxt = (HOME_MODE == MODE_PUSH) ? ST_TRAVEL : ST_ESCAPE;
          cnt_load = (HOME_MODE == MODE_PUSH);
        end
      end
      ST_ESCAPE:
      begin
        // wait clear of the limit sensor before the fixed travel
        if (!limit_pos_lvl && !limit_neg_lvl)
        begin
          cnt_load = 1'b1;
          state_nxt = ST_TRAVEL;
        end
      end
      ST_TRAVEL:
      begin
        if (cnt_done && !cnt_load)
        begin
          if (extra_en && HOME_MODE == MODE_TWO_SENSOR)
          begin
            run_nxt = 1'b0;
            speed_nxt = final_speed;
            state_nxt = ST_EXTRA;
          end
          else
          begin
            run_nxt = 1'b0;
            cmd_pos_nxt = HOME_POSITION;
            state_nxt = ST_OFFSET;
          end
        end
      end
      ST_EXTRA:
      begin
        run_nxt = 1'b1;
        // three-sensor needs origin still on when the extra edge lands
        if (extra_rise && (HOME_MODE != MODE_THREE_SENSOR || origin_lvl))
        begin
          run_nxt = 1'b0;
          cmd_pos_nxt = HOME_POSITION;
          state_nxt = ST_OFFSET;
        end
      end
      ST_OFFSET:
      begin
        // first entry loads the offset; zero offset finishes at once
        if (!run_r && offset_mag != '0 && cnt_done)
        begin
          cnt_load = 1'b1;
          cnt_value = offset_mag;
          dir_nxt = ~home_offset[OFFSET_WIDTH-1];
          speed_nxt = RUN_SPEED; // offset move runs at run speed
          run_nxt = 1'b1;
        end
        else if (run_r && cnt_done)
        begin
          run_nxt = 1'b0;
          cmd_pos_nxt = HOME_POSITION;
          ready_nxt = 1'b1;
          complete_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
        else if (!run_r && offset_mag == '0)
        begin
          ready_nxt = 1'b1;
          complete_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // state registers; outputs all come from these flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      dir_r <= DIR_DEFAULT;
      ready_r <= 1'b1;
      complete_r <= 1'b0;
      run_r <= 1'b0;
      speed_r <= START_SPEED_DEFAULT;
      push_on_r <= 1'b0;
      cmd_pos_r <= HOME_POSITION;
      accel_r <= ACCEL_DEFAULT;
      current_r <= PUSH_CURRENT_DEFAULT;
    end
    else
    begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
      ready_r <= ready_nxt;
      complete_r <= complete_nxt;
      run_r <= run_nxt;
      speed_r <= speed_nxt;
      push_on_r <= push_on_nxt;
      cmd_pos_r <= cmd_pos_nxt;
      // static settings, registered so these outputs come from flops too
      accel_r <= ACCEL_RATE;
      current_r <= PUSH_CURRENT;
    end
  end

  assign ready = ready_r;
  assign home_complete = complete_r;
  assign motor_run = run_r;
  assign motor_dir_pos = dir_r;
  assign motor_speed = speed_r;
  assign motor_accel = accel_r;
  assign motor_current = current_r;
  assign push_current_on = push_on_r;
  assign command_position = cmd_pos_r;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  ready_drops_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && ready_r && home_req_rise) |=> !ready_r && run_r)
    else $error("ready did not drop on request");
  seek_speed_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && ready_r && home_req_rise) |=>
      speed_r == ((HOME_MODE == MODE_THREE_SENSOR) ? RUN_SPEED : START_SPEED))
    else $error("wrong seek speed");
  start_dir_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && ready_r && home_req_rise) |=> dir_r == $past(start_positive))
    else $error("wrong start direction");
  home_zero_a: assert property (@(posedge clk) disable iff (reset)
    (state_r != ST_OFFSET && state_nxt == ST_OFFSET) |=> cmd_pos_r == HOME_POSITION)
    else $error("position not zeroed at home");
  preset_load_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && ready_r && !home_req_rise && preset_rise && !run_r) |=>
      cmd_pos_r == $past(preset_position))
    else $error("preset not loaded");
  final_speed_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_EXTRA) |-> speed_r <= FINAL_SPEED_CAP)
    else $error("final approach too fast");
  complete_ready_a: assert property (@(posedge clk) disable iff (reset)
    $rose(complete_r) |-> ready_r && !run_r && cmd_pos_r == HOME_POSITION)
    else $error("completion without ready at home");
  extra_needs_origin_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_EXTRA && HOME_MODE == MODE_THREE_SENSOR && state_nxt == ST_OFFSET) |-> origin_lvl)
    else $error("completed without origin on");

endmodule : return_to_home_sequencer

// *** machine_model.sv ***
/*
  machine_model: load on a linear axis with a pulse engine, origin, limit,
  stopper, slot and marker sensors, seen from the sequencer's pins.
  Assumes one sequencer drives motor_run and motor_dir_pos on clk.
*/
`timescale 1ns/10ps
module machine_model
#(
  parameter int ORG = 20,
  parameter int LIM = 300,
  parameter int STOP_AT = 1000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pulse engine
  input wire logic motor_run,
  input wire logic motor_dir_pos,
  output logic step_pulse,
  // sensors
  output logic origin_sensor,
  output logic limit_pos,
  output logic limit_neg,
  output logic stall_detect,
  output logic slot_sensor_input,
  output logic phase_marker_signal,
  // true load position
  output int pos
);
  // ---------------------------------------------------------------
  // step generation
  // ---------------------------------------------------------------
  logic [2:0] div_r;

  // one step every 8 cycles leaves room for the 3-cycle input sync, so no overshoot
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_r <= 3'h0;
      step_pulse <= 1'b0;
      pos <= 0;
    end
    else
    begin
      step_pulse <= motor_run && div_r == 3'h7;
      div_r <= motor_run ? div_r + 3'h1 : 3'h0;
      if (step_pulse)
        pos <= motor_dir_pos ? pos + 1 : pos - 1;
    end
  end

  // sensors as levels of position; the stopper only pushes back while pressed
  assign origin_sensor = pos >= ORG && pos < ORG + 10;
  assign limit_pos = pos >= LIM;
  assign limit_neg = pos <= -LIM;
  assign stall_detect = motor_dir_pos && pos >= STOP_AT;
  assign slot_sensor_input = pos >= ORG + 3 && pos < ORG + 6;
  // marker repeats every 8 steps, as a step resolution suited to the marker gives
  assign phase_marker_signal = (pos % 8) == 0;
endmodule : machine_model

// *** return_to_home_sequencer_bench.sv ***
/*
  return_to_home_sequencer_bench: one sequencer per homing mode, each on its
  own machine model; homing runs one unit at a time, then a preset.
  Assumes the models' geometry: origin 20, limits +-300, stopper 250 on the push unit and 1000 on the others.
*/
`timescale 1ns/10ps
module return_to_home_sequencer_bench;
  import homing_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct {int idx; int pos;} note_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic home_req [3];
  logic preset_req = 1'b0;
  logic start_pos = 1'b1;
  logic slot_en = 1'b0;
  logic mark_en = 1'b0;
  logic signed [OFFSET_WIDTH-1:0] offset_v = 24'h000000;
  logic [POS_WIDTH-1:0] preset_v = 32'h00000000;
  logic ready [3], hc [3], hc_prev [3], run [3], dir [3], step [3], org [3], lp [3], ln [3];
  logic stall [3], slot [3], mark [3], pcur_on [3];
  logic [SPEED_WIDTH-1:0] speed [3];
  logic [ACCEL_WIDTH-1:0] accel [3];
  logic [CURRENT_WIDTH-1:0] cur [3];
  logic [POS_WIDTH-1:0] cmd_pos [3];
  int pos [3];
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int off;
  int seed_dummy;
  note_type exp_q [$];
  note_type note;

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // units: index equals HOME_MODE
  // ---------------------------------------------------------------
  for (genvar m = 0; m < 3; m++)
  begin : g_unit
    return_to_home_sequencer #(.HOME_MODE(2'(m))) i_return_to_home_sequencer (
      .clk(clk), .reset(reset), .home_request(home_req[m]), .preset_request(preset_req),
      .ready(ready[m]), .home_complete(hc[m]), .start_positive(start_pos), .slot_detect_en(slot_en),
      .marker_detect_en(mark_en), .home_offset(offset_v), .preset_position(preset_v),
      .origin_sensor(org[m]), .travel_limit_pos(lp[m]), .travel_limit_neg(ln[m]),
      .stall_detect(stall[m]), .slot_sensor_input(slot[m]), .phase_marker_signal(mark[m]),
      .step_pulse(step[m]), .motor_run(run[m]), .motor_dir_pos(dir[m]), .motor_speed(speed[m]),
      .motor_accel(accel[m]), .motor_current(cur[m]), .push_current_on(pcur_on[m]),
      .command_position(cmd_pos[m]));
    machine_model #(.STOP_AT(m == 2 ? 250 : 1000)) i_machine_model (
      .clk(clk), .reset(reset), .motor_run(run[m]), .motor_dir_pos(dir[m]), .step_pulse(step[m]),
      .origin_sensor(org[m]), .limit_pos(lp[m]), .limit_neg(ln[m]), .stall_detect(stall[m]),
      .slot_sensor_input(slot[m]), .phase_marker_signal(mark[m]), .pos(pos[m]));
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expct, input string what);
    n_checks++;
    if (seen !== expct)
    begin
      fail_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, expct);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // the watcher pairs each completion with the oldest note
  always @(negedge clk)
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (hc[k] === 1'b1 && hc_prev[k] === 1'b0)
      begin
        if (exp_q.size() == 0)
          check(1, 0, "unexpected completion");
        else
        begin
          note = exp_q.pop_front();
          check(k, note.idx, "completing unit");
          check(pos[k], note.pos, "stop position");
          check(cmd_pos[k], HOME_POSITION, "command position");
          check(ready[k], 1'b1, "ready at completion");
        end
      end
      hc_prev[k] = hc[k];
    end
  end

  // hang guard, generous against the ~24k cycles of traffic
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // host driver
  // ---------------------------------------------------------------
  task automatic run_home(input int k, input int exp_pos, input logic [SPEED_WIDTH-1:0] exp_speed);
    int n;
    n = 0;
    exp_q.push_back('{k, exp_pos});
    @(negedge clk);
    home_req[k] = 1'b1;
    while (ready[k] !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(ready[k], 1'b0, "ready after request");
    home_req[k] = 1'b0;
    repeat (6) @(negedge clk);
    check(hc[k], 1'b0, "complete cleared at start");
    check(run[k], 1'b1, "motor running");
    check(speed[k], exp_speed, "seek speed");
    check(accel[k], ACCEL_DEFAULT, "seek accel");
    check(dir[k], start_pos, "start direction");
    check(pcur_on[k], k == 2, "push current on");
    if (k == 2)
      check(cur[k], PUSH_CURRENT_DEFAULT, "push current");
    n = 0;
    while (ready[k] !== 1'b1 && n < 10000)
    begin
      @(negedge clk);
      n++;
    end
    check(ready[k], 1'b1, "ready after homing");
    repeat (3) @(negedge clk);
  endtask : run_home

  initial
  begin
    for (int k = 0; k < 3; k++)
      home_req[k] = 1'b0;
    seed_dummy = $urandom(32'h9ec2);
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    run_home(1, 20, RUN_SPEED_DEFAULT);
    run_home(0, 99, START_SPEED_DEFAULT);
    run_home(2, 50, START_SPEED_DEFAULT);
    // offset run: second two-sensor homing, then a signed offset move
    off = int'($urandom_range(40)) - 20;
    if (off == 0)
      off = 5;
    offset_v = 24'(off);
    run_home(0, 99 + off, START_SPEED_DEFAULT);
    offset_v = 24'h000000;
    // three-sensor from inside origin: out to the limit, back, slot edge at 25 while origin on
    slot_en = 1'b1;
    run_home(1, 25, RUN_SPEED_DEFAULT);
    slot_en = 1'b0;
    // two-sensor: escape to 99, pause, then creep down to the marker at 96
    mark_en = 1'b1;
    run_home(0, 96, START_SPEED_DEFAULT);
    mark_en = 1'b0;
    // negative start: lower limit turns the two-sensor unit round, home at -99
    start_pos = 1'b0;
    run_home(0, -99, START_SPEED_DEFAULT);
    start_pos = 1'b1;
    // preset while every unit is stopped
    preset_v = $urandom();
    @(negedge clk);
    preset_req = 1'b1;
    repeat (8) @(negedge clk);
    preset_req = 1'b0;
    for (int k = 0; k < 3; k++)
      check(cmd_pos[k], preset_v, "preset position");
    check(exp_q.size(), 0, "notes left over");
    final_report();
  end
endmodule : return_to_home_sequencer_bench
